// ### verilog/tlpwm_sequencer.sv
/*
  tlpwm_sequencer: digital core of a two-phase buck controller. picks single
  or dual phase from straps, runs the internal or sync clock, drives the clock
  output and two tri-level pwm outputs with boot refresh and pulse skipping.
  assumes all inputs synchronous to clk; comparators and straps are digital.
*/
// How it works
// - dual phase unless one output strapped high
// - internal oscillator clamped to 500 kHz..3 MHz
// - frequency strap shorted means fault, no switching
// - sync lost or too slow falls back internally
// - clock output rate chosen by its strap
// - unloaded clock output follows phase b
// - clock output held low during fault
// - outputs use low, mid and high levels
// - power-up boot burst of 32 low pulses
// - boot pulses per cycle, min high time wide
// - 60 us in mid adds four refresh pulses
// - current sense comparator ends high pulse
// - too narrow demanded pulse is skipped
// - osc halved, phases alternate 180 degrees apart
`timescale 1ns/10ps
module tlpwm_sequencer
  import tlpwm_pkg::*;
#(
  parameter int MID_TIMER_CYCLES = MID_TIMER_CYC
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       strap_a_to_vcc,
  input  wire logic       strap_b_to_vcc,
  input  wire logic [1:0] clk_out_strap,
  input  wire logic [7:0] freq_set_strap,
  input  wire logic       freq_set_short,
  input  wire logic       sync_in,
  input  wire logic       start_req,
  input  wire logic       run_en,
  input  wire logic       fault_in,
  input  wire logic       current_sense_a_in,
  input  wire logic       current_sense_b_in,
  input  wire logic       skip_a,
  input  wire logic       skip_b,
  output logic [1:0]      phase_a_out,
  output logic [1:0]      phase_b_out,
  output logic            sync_out,
  output logic            single_phase,
  output logic            on_ext_clock,
  output logic            fault_active,
  output logic            boot_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // straps, caught once after reset release
  logic       cfg_done_reg;
  logic       use_a_reg;
  logic       use_b_reg;
  logic [1:0] clk_mode_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_done_reg <= 1'b0;
      use_a_reg    <= 1'b0;
      use_b_reg    <= 1'b0;
      clk_mode_reg <= CLKO_OPEN;
    end else if (!cfg_done_reg) begin
      cfg_done_reg <= 1'b1;
      // both strapped is meaningless; fall back to dual phase
      use_a_reg    <= ~strap_a_to_vcc | strap_b_to_vcc;
      use_b_reg    <= ~strap_b_to_vcc | strap_a_to_vcc;
      clk_mode_reg <= clk_out_strap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator and clock selection
  logic [7:0] int_cnt_reg;
  logic       ext_tick;
  logic       ext_ok;

  wire [7:0] int_period = (freq_set_strap < OSC_PER_MIN_CYC) ? OSC_PER_MIN_CYC :
                          (freq_set_strap > OSC_PER_MAX_CYC) ? OSC_PER_MAX_CYC :
                          freq_set_strap;
  wire       int_tick   = int_cnt_reg >= (int_period - 8'h01);
  wire       osc_tick   = ext_ok ? ext_tick : int_tick;

  tlpwm_sync_mon u_sync_mon (
    .clk        (clk),
    .reset      (reset),
    .sync_in    (sync_in),
    .int_period (int_period),
    .ext_tick   (ext_tick),
    .ext_ok     (ext_ok)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      int_cnt_reg <= 8'h00;
    end else begin
      int_cnt_reg <= (int_tick || (ext_ok && ext_tick)) ? 8'h00 : int_cnt_reg + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencing
  tlpwm_state_t state_reg;
  tlpwm_state_t state_next;
  logic         phase_sel_reg;
  logic [5:0]   boot_cnt_reg;
  logic [5:0]   boot_cnt_next;
  logic [15:0]  mid_cnt_reg;
  logic         fault_reg;
  logic         single_reg;
  logic         ext_reg;
  logic         boot_reg;

  wire fault_now   = fault_in | freq_set_short;
  wire a_start     = osc_tick & phase_sel_reg;  // phase a opens each other tick
  wire mid_expired = mid_cnt_reg >= 16'(MID_TIMER_CYCLES - 1);
  wire phase_sel_next = osc_tick ? ~phase_sel_reg : phase_sel_reg;

  always_comb begin
    state_next    = state_reg;
    boot_cnt_next = boot_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req && cfg_done_reg) begin
          state_next    = ST_BOOT;
          boot_cnt_next = BOOT_FIRST_PULSES;
        end
      end
      ST_BOOT: begin
        if (a_start) begin
          if (boot_cnt_reg == 6'h00) begin
            state_next = ST_MIDWAIT;
          end else begin
            boot_cnt_next = boot_cnt_reg - 6'h01;
          end
        end
      end
      ST_MIDWAIT: begin
        if (run_en) begin
          state_next = ST_RUN;
        end else if (mid_expired) begin
          state_next    = ST_BOOT;
          boot_cnt_next = BOOT_EXTRA_PULSES;
        end
      end
      ST_RUN: begin
        if (!run_en) begin
          state_next = ST_MIDWAIT;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (fault_now) begin
      state_next = ST_FAULT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      boot_cnt_reg  <= 6'h00;
      phase_sel_reg <= 1'b0;
      mid_cnt_reg   <= 16'h0000;
      fault_reg     <= 1'b0;
      single_reg    <= 1'b0;
      ext_reg       <= 1'b0;
      boot_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      boot_cnt_reg  <= boot_cnt_next;
      phase_sel_reg <= phase_sel_next;
      // timer restarts each time the outputs fall back to mid
      mid_cnt_reg   <= (state_reg == ST_MIDWAIT) ? mid_cnt_reg + 16'h0001 : 16'h0000;
      fault_reg     <= fault_now;
      single_reg    <= use_a_reg ^ use_b_reg;
      ext_reg       <= ext_ok;
      boot_reg      <= (state_next == ST_BOOT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-phase tri-level drivers
  logic [1:0] lvl_reg [2];
  wire  [1:0] sense_in = {current_sense_b_in, current_sense_a_in};
  wire  [1:0] skip_in  = {skip_b, skip_a};
  wire  [1:0] use_ph   = {use_b_reg, use_a_reg};

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_phase
      logic [7:0] wid_cnt_reg;
      // phase b opens half a switching period after phase a
      wire ph_start = osc_tick & (phase_sel_reg == (p == 0));
      wire boot_go  = (state_reg == ST_BOOT) && (state_next == ST_BOOT) && ph_start &&
                      !(p == 0 && boot_cnt_reg == 6'h00);
      wire [1:0] run_lvl = (ph_start && skip_in[p]) ? LVL_LOW :
                           ph_start ? LVL_HIGH :
                           (lvl_reg[p] == LVL_HIGH && sense_in[p]) ? LVL_LOW :
                           lvl_reg[p];
      wire [1:0] boot_lvl = boot_go ? LVL_LOW :
                            (lvl_reg[p] == LVL_LOW && wid_cnt_reg <= 8'h01) ? LVL_MID :
                            lvl_reg[p];
      wire [1:0] lvl_next = (!use_ph[p] || fault_now) ? LVL_MID :
                            (state_reg == ST_RUN && state_next == ST_RUN) ? run_lvl :
                            (state_reg == ST_BOOT) ? boot_lvl : LVL_MID;

      always_ff @(posedge clk) begin
        if (reset) begin
          lvl_reg[p]  <= LVL_MID;
          wid_cnt_reg <= 8'h00;
        end else begin
          lvl_reg[p]  <= lvl_next;
          wid_cnt_reg <= boot_go ? MIN_HIGH_CYC :
                         (wid_cnt_reg != 8'h00) ? wid_cnt_reg - 8'h01 : 8'h00;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // clock output
  logic       sync_out_reg;
  logic [7:0] osc_hi_reg;

  // oscillator rate as a pulse half an internal period wide
  wire osc_level = osc_tick | (osc_hi_reg != 8'h00);
  wire sync_out_next = fault_now ? 1'b0 :
                       (clk_mode_reg == CLKO_GND) ? osc_level :
                       (clk_mode_reg == CLKO_VCC) ? ~phase_sel_next :
                       phase_sel_next;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_out_reg <= 1'b0;
      osc_hi_reg   <= 8'h00;
    end else begin
      sync_out_reg <= sync_out_next;
      osc_hi_reg   <= osc_tick ? (int_period >> 1) :
                      (osc_hi_reg != 8'h00) ? osc_hi_reg - 8'h01 : 8'h00;
    end
  end

  assign phase_a_out  = lvl_reg[0];
  assign phase_b_out  = lvl_reg[1];
  assign sync_out     = sync_out_reg;
  assign single_phase = single_reg;
  assign on_ext_clock = ext_reg;
  assign fault_active = fault_reg;
  assign boot_busy    = boot_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_boot_low;
    phase_a_out == LVL_LOW [*8];
  endsequence

  a_fault_mid_out: assert property (fault_active |->
    (phase_a_out == LVL_MID && phase_b_out == LVL_MID))
    else $error("outputs not mid during fault");
  a_fault_clk_low: assert property (fault_active |-> !sync_out)
    else $error("clock output not low during fault");
  a_short_stops: assert property (freq_set_short |=> state_reg == ST_FAULT)
    else $error("frequency strap short did not stop switching");
  a_sense_ends_high: assert property ((state_reg == ST_RUN && run_en && !fault_now &&
    phase_a_out == LVL_HIGH && current_sense_a_in && !osc_tick) |=> phase_a_out == LVL_LOW)
    else $error("high pulse not ended by current sense");
  a_skip_stays_low: assert property ((state_reg == ST_RUN && run_en && !fault_now &&
    use_a_reg && osc_tick && phase_sel_reg && skip_a) |=> phase_a_out == LVL_LOW)
    else $error("narrow pulse was not skipped");
  a_boot_pulse_width: assert property ((!fault_now && use_a_reg &&
    $rose(phase_a_out == LVL_LOW) && boot_busy) |->
    s_boot_low ##1 (phase_a_out == LVL_MID || fault_active))
    else $error("boot refresh pulse width wrong");
  a_mid_timer_refresh: assert property ((state_reg == ST_MIDWAIT && mid_expired &&
    !run_en && !fault_now) |=> (state_reg == ST_BOOT && boot_cnt_reg == BOOT_EXTRA_PULSES))
    else $error("mid timer did not add refresh pulses");
  a_phase_alternate: assert property (osc_tick |=> phase_sel_reg != $past(phase_sel_reg))
    else $error("phases did not alternate");
  a_open_clk_phase: assert property ((cfg_done_reg && clk_mode_reg == CLKO_OPEN &&
    !fault_active) |-> sync_out == phase_sel_reg)
    else $error("unloaded clock output not with phase b");
  a_single_idle: assert property ((cfg_done_reg && !use_a_reg) |=>
    phase_a_out == LVL_MID)
    else $error("strapped phase a switched");

endmodule

// ### verilog/tlpwm_pkg.sv
/*
  tlpwm_pkg: constants shared by the two-phase tri-level pwm sequencer.
  assumes a 100 MHz system clock; all cycle counts derive from that rate.
*/
package tlpwm_pkg;

  localparam int CLK_KHZ          = 100000;
  localparam int CLK_PERIOD_NS    = 10;

  // oscillator range, internal and external sync
  localparam int OSC_MIN_KHZ      = 500;
  localparam int OSC_MAX_KHZ      = 3000;
  localparam int SYNC_MIN_KHZ     = 588;
  localparam int OSC_PER_MIN      = (CLK_KHZ + OSC_MAX_KHZ - 1) / OSC_MAX_KHZ;
  localparam int OSC_PER_MAX      = CLK_KHZ / OSC_MIN_KHZ;
  localparam int SYNC_PER_MAX     = CLK_KHZ / SYNC_MIN_KHZ;
  localparam logic [7:0] OSC_PER_MIN_CYC  = 8'(OSC_PER_MIN);
  localparam logic [7:0] OSC_PER_MAX_CYC  = 8'(OSC_PER_MAX);
  localparam logic [7:0] SYNC_PER_MAX_CYC = 8'(SYNC_PER_MAX);

  // internal must sit 15 % below external: ext * 100 <= int * 85, scaled by 5
  localparam logic [12:0] SYNC_MARGIN_EXT = 13'h0014;
  localparam logic [12:0] SYNC_MARGIN_INT = 13'h0011;

  // minimum high time of a pulse, also boot refresh low width
  localparam int MIN_HIGH_TIME_NS = 80;
  localparam int MIN_HIGH_CYC_I   = (MIN_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MIN_HIGH_CYC = 8'(MIN_HIGH_CYC_I);

  // mid-level boot refresh timer
  localparam int MID_TIMER_US     = 60;
  localparam int MID_TIMER_CYC    = MID_TIMER_US * (CLK_KHZ / 1000);

  localparam logic [5:0] BOOT_FIRST_PULSES = 6'h20;
  localparam logic [5:0] BOOT_EXTRA_PULSES = 6'h04;

  // tri-level output codes
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // clock output strap
  localparam logic [1:0] CLKO_OPEN = 2'h0;
  localparam logic [1:0] CLKO_GND  = 2'h1;
  localparam logic [1:0] CLKO_VCC  = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_BOOT, ST_MIDWAIT, ST_RUN, ST_FAULT} tlpwm_state_t;

endpackage

// ### verilog/tlpwm_sync_mon.sv
/*
  tlpwm_sync_mon: watches the external sync input, measures its period
  and says whether it may clock the sequencer.
  assumes sync_in is synchronous to clk and int_period is already clamped.
*/
`timescale 1ns/10ps
module tlpwm_sync_mon
  import tlpwm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sync_in,
  input  wire logic [7:0] int_period,
  output logic            ext_tick,
  output logic            ext_ok
);

  logic       sync_d_reg;
  logic [7:0] ext_cnt_reg;
  logic       ext_ok_reg;
  logic       ext_tick_reg;

  wire        rise       = sync_in & ~sync_d_reg;
  // out of range or too close to the internal rate: treat as absent
  wire        in_range   = (ext_cnt_reg >= OSC_PER_MIN_CYC) &&
                           (ext_cnt_reg <= SYNC_PER_MAX_CYC);
  wire        margin_ok  = (13'(ext_cnt_reg) * SYNC_MARGIN_EXT) <=
                           (13'(int_period) * SYNC_MARGIN_INT);
  // stuck high or low also ends here: no edge within one internal period
  wire        timed_out  = ext_cnt_reg > int_period;
  wire [7:0]  cnt_next   = rise ? 8'h01 :
                           (ext_cnt_reg == 8'hff) ? ext_cnt_reg : ext_cnt_reg + 8'h01;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_d_reg   <= 1'b0;
      ext_cnt_reg  <= 8'hff;
      ext_ok_reg   <= 1'b0;
      ext_tick_reg <= 1'b0;
    end else begin
      sync_d_reg   <= sync_in;
      ext_cnt_reg  <= cnt_next;
      ext_ok_reg   <= rise ? (in_range & margin_ok) : (ext_ok_reg & ~timed_out);
      ext_tick_reg <= rise & in_range & margin_ok;
    end
  end

  assign ext_tick = ext_tick_reg;
  assign ext_ok   = ext_ok_reg;

endmodule

// ### verification/tlpwm_driver_model.sv
/*
  tlpwm_driver_model: half-bridge driver fed by one tri-level phase output,
  with a crude current ramp feeding the sense comparator back.
  assumes lvl is the registered phase code of the sequencer.
*/
`timescale 1ns/10ps
module tlpwm_driver_model
  import tlpwm_pkg::*;
#(
  parameter int SENSE_DLY = 5
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] lvl,
  output logic            hs_on,
  output logic            ls_on,
  output logic            sense
);
  logic [7:0] ramp_reg;

  // high: top switch on, low: bottom switch on, mid: both off
  assign hs_on = (lvl == LVL_HIGH);
  assign ls_on = (lvl == LVL_LOW);

  // current only rises while the top switch conducts
  always_ff @(posedge clk) begin
    if (reset || !hs_on) begin
      ramp_reg <= 8'h00;
    end else begin
      ramp_reg <= ramp_reg + 8'h01;
    end
  end

  assign sense = hs_on && (ramp_reg >= 8'(SENSE_DLY));
endmodule

// ### verification/tlpwm_sequencer_tb.sv
/*
  tlpwm_sequencer_tb: self-checking bench for the tri-level sequencer.
  assumes 100 MHz clk; inputs change on the falling edge only.
*/
`timescale 1ns/10ps
module tlpwm_sequencer_tb;
  import tlpwm_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       sa = 1'b0, sb = 1'b0, start_req = 1'b0, run_en = 1'b0;
  logic       fault_in = 1'b0, fshort = 1'b0, skip_a = 1'b0, skip_b = 1'b0;
  logic       sync_in = 1'b0, sync_run = 1'b0;
  logic [1:0] cstrap = CLKO_OPEN;
  logic [7:0] fset = 8'h28;
  logic [1:0] pa, pb;
  logic       sync_out, single_phase, on_ext, fault_active, boot_busy, sns_a, sns_b;
  int         cyc = 0, scnt = 0, fail_count = 0, tests_run = 0;

  tlpwm_sequencer #(.MID_TIMER_CYCLES(200)) dut (
    .clk(clk), .reset(reset), .strap_a_to_vcc(sa), .strap_b_to_vcc(sb),
    .clk_out_strap(cstrap), .freq_set_strap(fset), .freq_set_short(fshort),
    .sync_in(sync_in), .start_req(start_req), .run_en(run_en), .fault_in(fault_in),
    .current_sense_a_in(sns_a), .current_sense_b_in(sns_b), .skip_a(skip_a),
    .skip_b(skip_b), .phase_a_out(pa), .phase_b_out(pb), .sync_out(sync_out),
    .single_phase(single_phase), .on_ext_clock(on_ext), .fault_active(fault_active),
    .boot_busy(boot_busy));
  tlpwm_driver_model drv_a (.clk(clk), .reset(reset), .lvl(pa), .hs_on(), .ls_on(),
    .sense(sns_a));
  tlpwm_driver_model drv_b (.clk(clk), .reset(reset), .lvl(pb), .hs_on(), .ls_on(),
    .sense(sns_b));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // external sync source: 40-cycle period, i.e. 2.5 MHz, twice switching rate
  always @(negedge clk) begin
    if (!sync_run) begin
      sync_in <= 1'b0;
      scnt <= 0;
    end else begin
      scnt <= (scnt == 19) ? 0 : scnt + 1;
      sync_in <= (scnt == 19) ? ~sync_in : sync_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: cond = (pa === LVL_LOW);
      1: cond = (pa === LVL_HIGH);
      2: cond = (pb === LVL_HIGH);
      3: cond = (sync_out === 1'b1);
      4: cond = (on_ext === 1'b1);
      5: cond = (pa !== LVL_MID);
      6: cond = (pb !== LVL_MID);
      default: cond = (pa !== LVL_MID) || (pb !== LVL_MID);
    endcase
  endfunction

  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_for(input int sel, input logic val, input int max, output int n);
    n = 0;
    while (cond(sel) !== val) begin
      @(negedge clk);
      n++;
      if (n > max) begin
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, ~val, val);
        complete_run();
      end
    end
  endtask

  // a real rising edge of the condition, then its width in cycles
  task automatic pulse(input int sel, input int max, output int w, output int t);
    int n;
    wait_for(sel, 1'b0, max, n);
    wait_for(sel, 1'b1, max, n);
    t = cyc;
    wait_for(sel, 1'b0, 300, w);
  endtask

  task automatic count(input int sel, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      c += int'(cond(sel));
    end
  endtask

  task automatic restart(input logic a, input logic b, input logic [1:0] cs,
                         input logic [7:0] f);
    reset = 1'b1;
    sa = a;
    sb = b;
    cstrap = cs;
    fset = f;
    run_en = 1'b0;
    fault_in = 1'b0;
    fshort = 1'b0;
    skip_a = 1'b0;
    skip_b = 1'b0;
    start_req = 1'b0;
    repeat (8) @(negedge clk);
    chk({pa, pb}, {LVL_MID, LVL_MID});
    reset = 1'b0;
    repeat (3) @(negedge clk);
    start_req = 1'b1;
    @(negedge clk);
    start_req = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    int w, t, tp, c;
    restart(1'b0, 1'b0, CLKO_OPEN, 8'h28);
    chk(single_phase, 1'b0);
    for (int i = 0; i < 32; i++) begin
      pulse(0, 400, w, t);
      chk(w, MIN_HIGH_CYC);
      if (i > 0) chk(t - tp, 80);
      if (i == 0) chk(boot_busy, 1'b1);
      tp = t;
    end
    count(0, 150, c);
    chk(c, 0);
    chk(boot_busy, 1'b0);
  endtask

  task automatic t_mid();
    int w, t, tp, c;
    pulse(0, 500, w, tp);
    for (int i = 1; i < 4; i++) begin
      pulse(0, 100, w, t);
      chk(t - tp, 80);
      tp = t;
    end
    count(0, 150, c);
    chk(c, 0);
  endtask

  task automatic t_run();
    int w, ta, tb, c, n;
    run_en = 1'b1;
    pulse(1, 200, w, ta);
    chk(w >= 6 && w <= 8, 1'b1);
    pulse(2, 100, w, tb);
    chk(tb - ta, 40);
    chk(sync_out, 1'b1);
    skip_a = 1'b1;
    count(1, 200, c);
    chk(c, 0);
    count(2, 200, c);
    chk(c > 0, 1'b1);
    skip_a = 1'b0;
    // phase b must be low before the skip request, so no pulse is cut
    wait_for(2, 1'b0, 100, n);
    skip_b = 1'b1;
    count(2, 200, c);
    chk(c, 0);
    count(1, 200, c);
    chk(c > 0, 1'b1);
    skip_b = 1'b0;
  endtask

  task automatic t_fault();
    int c;
    fault_in = 1'b1;
    @(negedge clk);
    chk({pa, pb, sync_out}, {LVL_MID, LVL_MID, 1'b0});
    @(negedge clk);
    chk(fault_active, 1'b1);
    count(7, 50, c);
    chk(c, 0);
    fault_in = 1'b0;
    fshort = 1'b1;
    start_req = 1'b1;
    count(7, 300, c);
    chk(c, 0);
    chk(sync_out, 1'b0);
  endtask

  task automatic t_single();
    int c;
    for (int i = 0; i < 2; i++) begin
      restart(i == 0, i == 1, CLKO_OPEN, 8'h28);
      chk(single_phase, 1'b1);
      count(5 + i, 400, c);
      chk(c, 0);
      count(6 - i, 400, c);
      chk(c > 0, 1'b1);
    end
  endtask

  // clock output rate per strap, and oscillator clamping at both ends
  task automatic t_strap();
    logic [1:0] cs [5] = '{CLKO_OPEN, CLKO_GND, CLKO_VCC, CLKO_GND, CLKO_GND};
    int         f [5] = '{40, 40, 40, 10, 250};
    int         e [5] = '{80, 40, 80, OSC_PER_MIN, OSC_PER_MAX};
    int         w, t1, t2;
    for (int i = 0; i < 5; i++) begin
      restart(1'b0, 1'b0, cs[i], 8'(f[i]));
      pulse(3, 600, w, t1);
      pulse(3, 600, w, t2);
      chk(t2 - t1, e[i]);
    end
  endtask

  task automatic t_sync();
    int n, w, t1, t2;
    restart(1'b0, 1'b0, CLKO_OPEN, 8'h3c);
    sync_run = 1'b1;
    wait_for(4, 1'b1, 600, n);
    chk(on_ext, 1'b1);
    pulse(3, 300, w, t1);
    pulse(3, 300, w, t2);
    chk(t2 - t1, 80);
    sync_run = 1'b0;
    wait_for(4, 1'b0, 200, n);
    chk(on_ext, 1'b0);
    pulse(0, 300, w, t1);
    chk(w, MIN_HIGH_CYC);
  endtask

  initial begin
    t_boot();
    t_mid();
    t_run();
    t_fault();
    t_single();
    t_strap();
    t_sync();
    complete_run();
  end
endmodule
